// ===== shared/cmp_skip_branch_pkg.sv
// Purpose: shared types and constants for the compare/skip/branch unit
// Assumes: 16-bit instruction words, 8-bit data, 16-bit word program counter
// Notes: flag positions follow the usual status register layout
package cmp_skip_branch_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP1 = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP2 = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP3 = 16'h0003;
    localparam logic [1:0] CYC_1 = 2'h1;
    localparam logic [1:0] CYC_2 = 2'h2;
    localparam logic [1:0] CYC_3 = 2'h3;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_CMP_BORROW = 5'h01,
        OP_CMP_IMM = 5'h02,
        OP_SKIP_REG_LOW = 5'h03,
        OP_SKIP_REG_HIGH = 5'h04,
        OP_SKIP_IO_LOW = 5'h05,
        OP_SKIP_IO_HIGH = 5'h06,
        OP_BR_SBIT_HIGH = 5'h07,
        OP_BR_SBIT_LOW = 5'h08,
        OP_BR_EQ = 5'h09,
        OP_BR_NE = 5'h0A,
        OP_BR_CARRY_HIGH = 5'h0B,
        OP_BR_CARRY_LOW = 5'h0C,
        OP_BR_NEG = 5'h0D,
        OP_BR_POS = 5'h0E,
        OP_BR_SGE = 5'h0F,
        OP_BR_SLT = 5'h10,
        OP_BR_HALF_HIGH = 5'h11,
        OP_BR_HALF_LOW = 5'h12
    } op_t;

    // one decoded instruction as handed over by fetch/decode
    typedef struct packed {
        op_t op;
        logic [DATA_W-1:0] dst;
        logic [DATA_W-1:0] src;
        logic [2:0] bit_sel;
        logic [OFS_W-1:0] offset;
        logic next_two_word;
    } instr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } state_t;
endpackage

// ===== hw/compare_skip_branch_unit.sv
// Purpose: executes compare, skip and conditional branch instructions
// Assumes: operands (register/io values) are presented with the issue strobe
// Notes: one instruction in flight; busy holds issue off while extra cycles run
`timescale 1ns/1ns
`default_nettype none
module compare_skip_branch_unit
    import cmp_skip_branch_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic issue,
    input wire instr_t instr,
    output logic busy_ff,
    output logic done_ff,
    output logic [PC_W-1:0] pc_ff,
    output logic [7:0] status_register_ff,
    output logic [1:0] cycles_ff
);
    state_t state_ff, nxt_state;
    logic nxt_busy, nxt_done;
    logic [PC_W-1:0] nxt_pc;
    logic [7:0] nxt_status;
    logic [1:0] nxt_cycles;
    logic [1:0] wait_ff, nxt_wait;

    logic [DATA_W-1:0] subtrahend, diff;
    logic borrow_in, carry_out, half_out, ovf_out, neg_out, zero_out;
    logic is_cmp, is_skip, is_branch, cond;
    logic [PC_W-1:0] branch_target, skip_step;

    // shared subtractor for both compares; result is never stored
    always_comb begin
        subtrahend = instr.src;
        borrow_in = 1'b0;
        if (instr.op == OP_CMP_BORROW) begin
            borrow_in = status_register_ff[FLAG_C];
        end
        {carry_out, diff} = {1'b0, instr.dst} - {1'b0, subtrahend} - {8'h00, borrow_in};
        half_out = (~instr.dst[3] & subtrahend[3]) | (subtrahend[3] & diff[3])
            | (diff[3] & ~instr.dst[3]);
        ovf_out = (instr.dst[7] & ~subtrahend[7] & ~diff[7])
            | (~instr.dst[7] & subtrahend[7] & diff[7]);
        neg_out = diff[7];
        zero_out = (diff == 8'h00);
        if (instr.op == OP_CMP_BORROW) begin
            // zero only stays set if it was already set
            zero_out = zero_out & status_register_ff[FLAG_Z];
        end
    end

    always_comb begin
        is_cmp = (instr.op == OP_CMP_BORROW) || (instr.op == OP_CMP_IMM);
        is_skip = 1'b0;
        is_branch = 1'b0;
        cond = 1'b0;
        case (instr.op)
            OP_SKIP_REG_LOW: begin
                is_skip = 1'b1;
                cond = ~instr.src[instr.bit_sel];
            end
            OP_SKIP_REG_HIGH: begin
                is_skip = 1'b1;
                cond = instr.src[instr.bit_sel];
            end
            OP_SKIP_IO_LOW: begin
                is_skip = 1'b1;
                cond = ~instr.src[instr.bit_sel];
            end
            OP_SKIP_IO_HIGH: begin
                is_skip = 1'b1;
                cond = instr.src[instr.bit_sel];
            end
            OP_BR_SBIT_HIGH: begin
                is_branch = 1'b1;
                cond = status_register_ff[instr.bit_sel];
            end
            OP_BR_SBIT_LOW: begin
                is_branch = 1'b1;
                cond = ~status_register_ff[instr.bit_sel];
            end
            OP_BR_EQ: begin
                is_branch = 1'b1;
                cond = status_register_ff[FLAG_Z];
            end
            OP_BR_NE: begin
                is_branch = 1'b1;
                cond = ~status_register_ff[FLAG_Z];
            end
            OP_BR_CARRY_HIGH: begin
                is_branch = 1'b1;
                cond = status_register_ff[FLAG_C];
            end
            OP_BR_CARRY_LOW: begin
                is_branch = 1'b1;
                cond = ~status_register_ff[FLAG_C];
            end
            OP_BR_NEG: begin
                is_branch = 1'b1;
                cond = status_register_ff[FLAG_N];
            end
            OP_BR_POS: begin
                is_branch = 1'b1;
                cond = ~status_register_ff[FLAG_N];
            end
            OP_BR_SGE: begin
                is_branch = 1'b1;
                cond = ~(status_register_ff[FLAG_N] ^ status_register_ff[FLAG_V]);
            end
            OP_BR_SLT: begin
                is_branch = 1'b1;
                cond = status_register_ff[FLAG_N] ^ status_register_ff[FLAG_V];
            end
            OP_BR_HALF_HIGH: begin
                is_branch = 1'b1;
                cond = status_register_ff[FLAG_H];
            end
            OP_BR_HALF_LOW: begin
                is_branch = 1'b1;
                cond = ~status_register_ff[FLAG_H];
            end
            default: begin
                cond = 1'b0;
            end
        endcase
        // signed word displacement, relative to the following word
        branch_target = pc_ff + {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset}
            + PC_STEP1;
        skip_step = instr.next_two_word ? PC_STEP3 : PC_STEP2;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_pc = pc_ff;
        nxt_status = status_register_ff;
        nxt_cycles = cycles_ff;
        nxt_wait = wait_ff;
        case (state_ff)
            ST_IDLE: begin
                if (issue && instr.op != OP_NONE) begin
                    nxt_cycles = CYC_1;
                    nxt_pc = pc_ff + PC_STEP1;
                    if (is_cmp) begin
                        nxt_status[FLAG_C] = carry_out;
                        nxt_status[FLAG_Z] = zero_out;
                        nxt_status[FLAG_N] = neg_out;
                        nxt_status[FLAG_V] = ovf_out;
                        nxt_status[FLAG_H] = half_out;
                    end
                    if (is_skip && cond) begin
                        nxt_pc = pc_ff + skip_step;
                        nxt_cycles = instr.next_two_word ? CYC_3 : CYC_2;
                    end
                    if (is_branch && cond) begin
                        nxt_pc = branch_target;
                        nxt_cycles = CYC_2;
                    end
                    if (nxt_cycles == CYC_1) begin
                        nxt_done = 1'b1;
                    end else begin
                        nxt_state = ST_WAIT;
                        nxt_busy = 1'b1;
                        nxt_wait = nxt_cycles - CYC_1;
                    end
                end
            end
            ST_WAIT: begin
                nxt_wait = wait_ff - CYC_1;
                if (wait_ff == CYC_1) begin
                    nxt_state = ST_IDLE;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pc_ff <= PC_RESET;
            status_register_ff <= STATUS_REGISTER_RESET;
            cycles_ff <= 2'h0;
            wait_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            pc_ff <= nxt_pc;
            status_register_ff <= nxt_status;
            cycles_ff <= nxt_cycles;
            wait_ff <= nxt_wait;
        end
    end

    sequence take_branch_s;
        state_ff == ST_IDLE && issue && is_branch && cond;
    endsequence

    sequence take_skip_s;
        state_ff == ST_IDLE && issue && is_skip && cond;
    endsequence

    branch_pc_a: assert property (@(posedge clk) disable iff (reset)
        take_branch_s |=> pc_ff == $past(branch_target))
        else $error("taken branch target wrong");

    branch_time_a: assert property (@(posedge clk) disable iff (reset)
        take_branch_s |=> busy_ff ##1 done_ff && !busy_ff)
        else $error("taken branch not two cycles");

    skip_two_a: assert property (@(posedge clk) disable iff (reset)
        (take_skip_s and instr.next_two_word) |=> busy_ff ##1 busy_ff ##1 done_ff)
        else $error("two word skip not three cycles");

    skip_pc_a: assert property (@(posedge clk) disable iff (reset)
        take_skip_s |=> pc_ff == $past(pc_ff) + $past(skip_step))
        else $error("skip step wrong");

    untaken_pc_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && (is_branch || is_skip) && !cond
        |=> pc_ff == $past(pc_ff) + PC_STEP1 && done_ff)
        else $error("untaken not one step");

    flags_kept_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && (is_branch || is_skip)
        |=> $stable(status_register_ff))
        else $error("flags changed by branch or skip");

    cmp_carry_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_CMP_IMM
        |=> status_register_ff[FLAG_C] == ($past(instr.dst) < $past(instr.src)) && done_ff)
        else $error("compare carry wrong");

    cmp_zero_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_CMP_BORROW
        |=> status_register_ff[FLAG_Z] == ($past(status_register_ff[FLAG_Z])
        && $past(instr.dst) == $past(instr.src) + $past(status_register_ff[FLAG_C])))
        else $error("borrow compare zero wrong");

    sge_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_SGE
        |-> cond == (status_register_ff[FLAG_N] == status_register_ff[FLAG_V]))
        else $error("signed ge condition wrong");

    sequence cmp_issue_s;
        state_ff == ST_IDLE && issue && is_cmp;
    endsequence

    sequence wait_one_s;
        busy_ff ##1 done_ff && !busy_ff;
    endsequence

    skip_one_a: assert property (@(posedge clk) disable iff (reset)
        (take_skip_s and !instr.next_two_word) |=> wait_one_s)
        else $error("one word skip not two cycles");

    cmp_time_a: assert property (@(posedge clk) disable iff (reset)
        cmp_issue_s |=> done_ff && !busy_ff && cycles_ff == CYC_1
        && pc_ff == $past(pc_ff) + PC_STEP1)
        else $error("compare not one cycle");

    borrow_carry_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_CMP_BORROW
        |=> status_register_ff[FLAG_C] == ({1'b0, $past(instr.dst)}
        < {1'b0, $past(instr.src)} + $past(status_register_ff[FLAG_C])))
        else $error("borrow compare carry wrong");

    imm_zero_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_CMP_IMM
        |=> status_register_ff[FLAG_Z] == ($past(instr.dst) == $past(instr.src)))
        else $error("compare zero wrong");

    cmp_others_a: assert property (@(posedge clk) disable iff (reset)
        cmp_issue_s |=> $stable(status_register_ff[FLAG_S])
        && $stable(status_register_ff[7:FLAG_H+1]))
        else $error("compare touched other flags");

    busy_hold_a: assert property (@(posedge clk) disable iff (reset)
        busy_ff |=> $stable(pc_ff) && $stable(status_register_ff))
        else $error("state moved while busy");

    sbit_taken_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_SBIT_HIGH
        && status_register_ff[instr.bit_sel] |=> busy_ff && cycles_ff == CYC_2)
        else $error("set status bit branch not taken");

    sbit_kept_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_SBIT_LOW
        && status_register_ff[instr.bit_sel] |=> done_ff && !busy_ff && cycles_ff == CYC_1)
        else $error("clear status bit branch taken");

    eq_untaken_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_EQ
        && !status_register_ff[FLAG_Z] |=> done_ff && !busy_ff)
        else $error("equal branch taken without zero");

    carry_taken_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_CARRY_HIGH
        && status_register_ff[FLAG_C] |=> busy_ff)
        else $error("carry branch not taken");

    half_low_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_HALF_LOW
        |=> busy_ff == !$past(status_register_ff[FLAG_H]))
        else $error("half carry clear branch wrong");

    lt_branch_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_BR_SLT
        |=> busy_ff == ($past(status_register_ff[FLAG_N])
        != $past(status_register_ff[FLAG_V])))
        else $error("signed less branch wrong");

    io_low_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_SKIP_IO_LOW
        && !instr.src[instr.bit_sel] |=> busy_ff)
        else $error("clear io bit skip not taken");

    io_high_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && issue && instr.op == OP_SKIP_IO_HIGH
        && !instr.src[instr.bit_sel] |=> done_ff && !busy_ff)
        else $error("set io bit skip taken on clear bit");
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for the compare/skip/branch unit
// Assumes: pc, flags and cycle count settle on the edge that takes issue
// Notes: expected values come from a small reference model kept here
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cmp_skip_branch_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic issue = 1'b0;
    instr_t instr = '0;
    logic busy_ff;
    logic done_ff;
    logic [PC_W-1:0] pc_ff;
    logic [7:0] status_register_ff;
    logic [1:0] cycles_ff;
    logic [PC_W-1:0] pc_e = PC_RESET;
    logic [7:0] sr_e = STATUS_REGISTER_RESET;
    logic [1:0] cy_e;
    int miscompares = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    compare_skip_branch_unit compare_skip_branch_unit_inst (.clk(clk), .reset(reset),
        .issue(issue), .instr(instr), .busy_ff(busy_ff), .done_ff(done_ff), .pc_ff(pc_ff),
        .status_register_ff(status_register_ff), .cycles_ff(cycles_ff));

    task automatic chk(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // reference model: flags, next pc and cycle count of one instruction
    task automatic predict(input op_t op, input logic [7:0] d, input logic [7:0] s,
            input logic [2:0] b, input logic [OFS_W-1:0] k, input logic tw);
        logic [7:0] r;
        logic t;
        t = 1'b0;
        cy_e = CYC_1;
        r = d - s - ((op == OP_CMP_BORROW) ? sr_e[FLAG_C] : 1'b0);
        case (op)
            OP_CMP_BORROW, OP_CMP_IMM: begin
                sr_e[FLAG_H] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
                sr_e[FLAG_V] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
                sr_e[FLAG_N] = r[7];
                sr_e[FLAG_C] = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
                sr_e[FLAG_Z] = (r == 8'h00) & ((op == OP_CMP_IMM) | sr_e[FLAG_Z]);
            end
            OP_SKIP_REG_LOW, OP_SKIP_IO_LOW: t = !s[b];
            OP_SKIP_REG_HIGH, OP_SKIP_IO_HIGH: t = s[b];
            OP_BR_SBIT_HIGH: t = sr_e[b];
            OP_BR_SBIT_LOW: t = !sr_e[b];
            OP_BR_EQ: t = sr_e[FLAG_Z];
            OP_BR_NE: t = !sr_e[FLAG_Z];
            OP_BR_CARRY_HIGH: t = sr_e[FLAG_C];
            OP_BR_CARRY_LOW: t = !sr_e[FLAG_C];
            OP_BR_NEG: t = sr_e[FLAG_N];
            OP_BR_POS: t = !sr_e[FLAG_N];
            OP_BR_SGE: t = !(sr_e[FLAG_N] ^ sr_e[FLAG_V]);
            OP_BR_SLT: t = sr_e[FLAG_N] ^ sr_e[FLAG_V];
            OP_BR_HALF_HIGH: t = sr_e[FLAG_H];
            OP_BR_HALF_LOW: t = !sr_e[FLAG_H];
            default: t = 1'b0;
        endcase
        if (op >= OP_SKIP_REG_LOW && op <= OP_SKIP_IO_HIGH) begin
            cy_e = t ? (tw ? CYC_3 : CYC_2) : CYC_1;
            pc_e = pc_e + (t ? (tw ? PC_STEP3 : PC_STEP2) : PC_STEP1);
        end else if (t) begin
            cy_e = CYC_2;
            pc_e = pc_e + {{(PC_W-OFS_W){k[OFS_W-1]}}, k} + PC_STEP1;
        end else begin
            pc_e = pc_e + PC_STEP1;
        end
    endtask

    task automatic drive(input op_t op, input logic [7:0] d, input logic [7:0] s,
            input logic [2:0] b, input logic [OFS_W-1:0] k, input logic tw);
        issue = 1'b1;
        instr = '{op, d, s, b, k, tw};
        predict(op, d, s, b, k, tw);
    endtask

    task automatic go(input op_t op, input logic [7:0] d, input logic [7:0] s,
            input logic [2:0] b, input logic [OFS_W-1:0] k, input logic tw);
        int n;
        drive(op, d, s, b, k, tw);
        @(negedge clk);
        issue = 1'b0;
        chk(busy_ff, cy_e != CYC_1);
        n = 1;
        while (done_ff !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk(n[PC_W-1:0], cy_e);
        chk(cycles_ff, cy_e);
        chk(pc_ff, pc_e);
        chk(status_register_ff, sr_e);
        @(negedge clk);
        chk(done_ff, 1'b0);
    endtask

    task automatic t_reset;
        issue = 1'b0;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        chk({busy_ff, done_ff, cycles_ff}, 4'h0);
        chk(pc_ff, PC_RESET);
        chk(status_register_ff, STATUS_REGISTER_RESET);
        reset = 1'b0;
        pc_e = PC_RESET;
        sr_e = STATUS_REGISTER_RESET;
        @(negedge clk);
        chk(pc_ff, PC_RESET);
    endtask

    // each flag setup is followed by every branch kind; flag branches alternate offset direction by setup, set-bit ones jump forward, clear-bit back
    task automatic t_branches;
        logic [7:0] sd[8] = '{8'h5A, 8'h07, 8'h00, 8'h05, 8'h80, 8'h7F, 8'h10, 8'h10};
        logic [7:0] ss[8] = '{8'h5A, 8'h07, 8'h01, 8'h04, 8'h01, 8'h80, 8'h00, 8'h01};
        logic [7:0] borrow = 8'h6A;
        for (int i = 0; i < 8; i++) begin
            go(borrow[i] ? OP_CMP_BORROW : OP_CMP_IMM, sd[i], ss[i], 3'h0, 7'h00, 1'b0);
            for (int o = OP_BR_EQ; o <= OP_BR_HALF_LOW; o++) begin
                go(op_t'(o), 8'h00, 8'h00, 3'h0, i[0] ? 7'h7D : 7'h0C, 1'b0);
            end
            for (int b = 0; b < 8; b++) begin
                go(OP_BR_SBIT_HIGH, 8'h00, 8'h00, b[2:0], 7'h3F, 1'b0);
                go(OP_BR_SBIT_LOW, 8'h00, 8'h00, b[2:0], 7'h40, 1'b0);
            end
        end
    endtask

    task automatic t_skips;
        logic [2:0] sel;
        logic [7:0] m;
        for (int o = OP_SKIP_REG_LOW; o <= OP_SKIP_IO_HIGH; o++) begin
            for (int c = 0; c < 4; c++) begin
                sel = 3'(o + c * 3);
                m = 8'h01 << sel;
                go(op_t'(o), 8'h00, c[0] ? m : ~m, sel, 7'h00, c[1]);
            end
        end
    endtask

    task automatic t_back_to_back;
        drive(OP_CMP_IMM, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0);
        @(negedge clk);
        drive(OP_CMP_BORROW, 8'h20, 8'h10, 3'h0, 7'h00, 1'b0);
        @(negedge clk);
        issue = 1'b0;
        chk(done_ff, 1'b1);
        chk(status_register_ff, sr_e);
        chk(pc_ff, pc_e);
        @(negedge clk);
    endtask

    // a compare offered while the taken branch is busy must be ignored
    task automatic t_refused;
        go(OP_CMP_IMM, 8'h5A, 8'h5A, 3'h0, 7'h00, 1'b0);
        drive(OP_BR_EQ, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0);
        @(negedge clk);
        instr = '{OP_CMP_IMM, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0};
        chk(busy_ff, 1'b1);
        @(negedge clk);
        issue = 1'b0;
        chk(done_ff, 1'b1);
        chk(pc_ff, pc_e);
        chk(status_register_ff, sr_e);
        @(negedge clk);
    endtask

    initial begin
        #200000;
        miscompares++;
        close_out;
    end

    initial begin
        t_reset;
        t_branches;
        t_skips;
        t_back_to_back;
        t_refused;
        drive(OP_BR_SBIT_LOW, 8'h00, 8'h00, 3'h7, 7'h10, 1'b0);
        @(negedge clk);
        t_reset;
        go(OP_CMP_IMM, 8'h01, 8'h02, 3'h0, 7'h00, 1'b0);
        close_out;
    end
endmodule
`default_nettype wire
